// File: inc/hsio_pkg.sv
// package for the host serial and I/O line configuration block
// assumes a single 125 MHz clock and synchronous active-low reset
package hsio_pkg;

  // clock and derived rates
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BAUD_STD_MAX = 7;
  localparam logic [31:0] BAUD_NS_MIN = 32'h00000080;
  localparam logic [31:0] BAUD_NS_MAX = 32'h0003D090;
  localparam logic [31:0] BAUD_RESET = 32'h00000003;

  // config field reset values
  localparam logic [7:0] GAP_RESET = 8'h03;
  localparam logic [7:0] FRAMED_RESET = 8'h00;
  localparam logic [7:0] PARITY_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'hFF;
  localparam logic [7:0] L8_RESET = 8'h00;
  localparam logic [7:0] L7_RESET = 8'h01;
  localparam logic [7:0] L6_RESET = 8'h00;
  localparam logic [7:0] L5_RESET = 8'h01;
  localparam logic [7:0] ALINE_RESET = 8'h00;
  localparam logic [7:0] FWD_RESET = 8'h01;

  // limits of the ranged settings
  localparam logic [7:0] FRAMED_MAX = 8'h02;
  localparam logic [7:0] PARITY_MAX = 8'h04;
  localparam logic [7:0] FWD_MAX = 8'h01;

  // pull-up mask bit positions
  localparam int unsigned PU_RTS_BIT = 5;
  localparam int unsigned PU_SLEEP_BIT = 6;
  localparam int unsigned PU_DIN_BIT = 7;
  localparam int unsigned NUM_ALINES = 5;

  // line function codes
  localparam logic [7:0] FN_DISABLED = 8'h00;
  localparam logic [7:0] FN_SPECIAL = 8'h01;
  localparam logic [7:0] FN_ADC = 8'h02;
  localparam logic [7:0] FN_DIN = 8'h03;
  localparam logic [7:0] FN_DO_LOW = 8'h04;
  localparam logic [7:0] FN_DO_HIGH = 8'h05;
  localparam logic [7:0] FN_TXEN_LOW = 8'h06;
  localparam logic [7:0] FN_TXEN_HIGH = 8'h07;

  // parity codes
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;

  // character framing: start + 8 data + optional parity + stop
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] BITS_NOPAR = 4'hA;
  localparam logic [3:0] BITS_PAR = 4'hB;

  // configuration selectors
  typedef enum logic [3:0] {
    HSIO_SEL_RATE, HSIO_SEL_GAP, HSIO_SEL_FRAMED, HSIO_SEL_PARITY, HSIO_SEL_PULLUP,
    HSIO_SEL_L8, HSIO_SEL_L7, HSIO_SEL_L6, HSIO_SEL_L5, HSIO_SEL_ALINE,
    HSIO_SEL_FWD
  } hsio_sel_t;

  // configuration command from the command parser
  typedef struct packed {
    logic wr;
    logic rd;
    hsio_sel_t sel;
    logic [2:0] idx;
    logic [31:0] data;
  } hsio_cmd_t;

  // configuration response
  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] data;
  } hsio_rsp_t;

  // byte stream word
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } hsio_byte_t;

endpackage : hsio_pkg

// File: logic/hsio_core.sv
// host serial port and I/O line configuration block
// assumes a command parser in front and a radio packet sink behind; one clock
`timescale 1ns/1ns
`default_nettype none

// Function
// R01: rate codes 0..7 select 1200..115200 bps
// R02: accept 0x80..0x3D090, read back achieved rate
// R03: gather characters until configured idle gap
// R04: zero gap sends each character alone
// R05: framed mode 0,1,2 only
// R06: eight data bits, five parity choices
// R07: pull-up mask bits map to lines
// R08: line eight only disabled or input
// R09: line seven functions incl. transceiver enable
// R10: line six functions incl. request-to-send
// R11: line five functions incl. association blink
// R12: analog lines independent, code 1 unavailable
// R13: forward remote I/O only when enabled
// R14: reject bad values, keep old setting
// R15: flow control pauses transfers
module hsio_core (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // configuration command port
  input wire hsio_pkg::hsio_cmd_t cmd_i,
  output hsio_pkg::hsio_rsp_t rsp_o,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  // radio side: outgoing packet bytes
  output hsio_pkg::hsio_byte_t pkt_o,
  output logic pkt_valid_o,
  input wire logic pkt_ready_i,
  // remote I/O frames to forward to host
  input wire logic [7:0] rio_data_i,
  input wire logic rio_valid_i,
  output logic rio_ready_o,
  // I/O lines 0..7 (three-signal form), input line 8
  input wire logic [7:0] line_i,
  output logic [7:0] line_o,
  output logic [7:0] line_oen_o,
  input wire logic line8_i,
  // status and pad control
  input wire logic assoc_blink_i,
  output logic [7:0] pullup_o,
  output logic [7:0] adc_en_o,
  output logic [8:0] din_o,
  output logic [7:0] framed_mode_o,
  output logic [2:0] parity_o
);
  import hsio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [31:0] rate_reg, rate_next;
  logic [7:0] gap_reg, framed_reg, parity_reg, pullup_reg, fwd_reg;
  logic [7:0] l8_reg, l7_reg, l6_reg, l5_reg;
  logic [7:0] aline_reg [NUM_ALINES];
  logic [31:0] div_reg, div_next;
  logic ok;
  logic [7:0] v;

  assign v = cmd_i.data[7:0];

  // value check per selector; out-of-range leaves the register alone
  always_comb begin
    ok = 1'b0;
    rate_next = rate_reg;
    div_next = div_reg;
    unique case (cmd_i.sel)
      HSIO_SEL_RATE: begin
        if (cmd_i.data <= 32'(BAUD_STD_MAX)) begin
          ok = 1'b1; // R01
          rate_next = cmd_i.data;
          div_next = std_div(cmd_i.data[2:0]);
        end else if (cmd_i.data >= BAUD_NS_MIN && cmd_i.data <= BAUD_NS_MAX) begin
          ok = 1'b1; // R02
          div_next = 32'(CLK_HZ) / cmd_i.data;
          rate_next = 32'(CLK_HZ) / div_next; // achieved, not requested
        end
      end
      HSIO_SEL_GAP: ok = (cmd_i.data[31:8] == 24'h000000); // R03
      HSIO_SEL_FRAMED: ok = (cmd_i.data <= 32'(FRAMED_MAX)); // R05
      HSIO_SEL_PARITY: ok = (cmd_i.data <= 32'(PARITY_MAX)); // R06
      HSIO_SEL_PULLUP: ok = (cmd_i.data[31:8] == 24'h000000); // R07
      HSIO_SEL_L8: ok = (cmd_i.data == 32'(FN_DISABLED)) || (cmd_i.data == 32'(FN_DIN)); // R08
      HSIO_SEL_L7: ok = (cmd_i.data <= 32'(FN_TXEN_HIGH)) && (v != FN_ADC); // R09
      HSIO_SEL_L6: ok = (cmd_i.data <= 32'(FN_DO_HIGH)) && (v != FN_ADC); // R10
      HSIO_SEL_L5: ok = (cmd_i.data <= 32'(FN_DO_HIGH)); // R11
      HSIO_SEL_ALINE: ok = (cmd_i.data <= 32'(FN_DO_HIGH)) && (v != FN_SPECIAL)
                           && (cmd_i.idx < 3'(NUM_ALINES)); // R12
      HSIO_SEL_FWD: ok = (cmd_i.data <= 32'(FWD_MAX)); // R13
      default: ok = 1'b0;
    endcase
  end

  // divisor for each standard rate, in clocks per bit
  function automatic logic [31:0] std_div(input logic [2:0] code);
    logic [31:0] bps;
    bps = 32'd1200 << code; // R01
    if (code == 3'h5) bps = 32'd38400;
    if (code == 3'h6) bps = 32'd57600;
    if (code == 3'h7) bps = 32'd115200;
    std_div = 32'(CLK_HZ) / bps;
  endfunction : std_div

  // register writes, committed only for accepted values
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rate_reg <= BAUD_RESET;
      div_reg <= std_div(BAUD_RESET[2:0]);
      gap_reg <= GAP_RESET;
      framed_reg <= FRAMED_RESET;
      parity_reg <= PARITY_RESET;
      pullup_reg <= PULLUP_RESET;
      l8_reg <= L8_RESET;
      l7_reg <= L7_RESET;
      l6_reg <= L6_RESET;
      l5_reg <= L5_RESET;
      fwd_reg <= FWD_RESET;
      for (int i = 0; i < NUM_ALINES; i++) aline_reg[i] <= ALINE_RESET;
    end else if (cmd_i.wr && ok) begin // R14
      unique case (cmd_i.sel)
        HSIO_SEL_RATE: begin
          rate_reg <= rate_next;
          div_reg <= div_next;
        end
        HSIO_SEL_GAP: gap_reg <= v;
        HSIO_SEL_FRAMED: framed_reg <= v;
        HSIO_SEL_PARITY: parity_reg <= v;
        HSIO_SEL_PULLUP: pullup_reg <= v;
        HSIO_SEL_L8: l8_reg <= v;
        HSIO_SEL_L7: l7_reg <= v;
        HSIO_SEL_L6: l6_reg <= v;
        HSIO_SEL_L5: l5_reg <= v;
        HSIO_SEL_ALINE: aline_reg[cmd_i.idx] <= v;
        HSIO_SEL_FWD: fwd_reg <= v;
        default: ;
      endcase
    end
  end

  // response one cycle after the command
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= cmd_i.wr | cmd_i.rd;
      rsp_o.err <= cmd_i.wr & ~ok; // R14
      unique case (cmd_i.sel)
        HSIO_SEL_RATE: rsp_o.data <= rate_reg; // R02
        HSIO_SEL_GAP: rsp_o.data <= {24'h000000, gap_reg};
        HSIO_SEL_FRAMED: rsp_o.data <= {24'h000000, framed_reg};
        HSIO_SEL_PARITY: rsp_o.data <= {24'h000000, parity_reg};
        HSIO_SEL_PULLUP: rsp_o.data <= {24'h000000, pullup_reg};
        HSIO_SEL_L8: rsp_o.data <= {24'h000000, l8_reg};
        HSIO_SEL_L7: rsp_o.data <= {24'h000000, l7_reg};
        HSIO_SEL_L6: rsp_o.data <= {24'h000000, l6_reg};
        HSIO_SEL_L5: rsp_o.data <= {24'h000000, l5_reg};
        HSIO_SEL_ALINE: rsp_o.data <= (cmd_i.idx < 3'(NUM_ALINES)) ?
                                      {24'h000000, aline_reg[cmd_i.idx]} : 32'h00000000;
        HSIO_SEL_FWD: rsp_o.data <= {24'h000000, fwd_reg};
        default: rsp_o.data <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line function decode; line n uses aline for 0..4, then 5, 6, 7
  logic [7:0] fn [8];
  logic cts_en, rts_en, rts_stop;
  always_comb begin
    for (int i = 0; i < NUM_ALINES; i++) fn[i] = aline_reg[i];
    fn[5] = l5_reg;
    fn[6] = l6_reg;
    fn[7] = l7_reg;
  end
  assign cts_en = (l7_reg == FN_SPECIAL);
  assign rts_en = (l6_reg == FN_SPECIAL);
  assign rts_stop = rts_en & line_i[6]; // host holds its request high: not ready

  logic tx_busy;
  logic [1:0] buf_cnt;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_line
      logic drive, lvl;
      always_comb begin
        drive = 1'b1;
        lvl = 1'b0;
        unique case (fn[g])
          FN_DO_LOW: lvl = 1'b0; // R12
          FN_DO_HIGH: lvl = 1'b1;
          FN_SPECIAL: begin
            drive = (g == 5) || (g == 7);
            lvl = (g == 5) ? assoc_blink_i : (buf_cnt == 2'h2); // R11 R15
          end
          FN_TXEN_LOW: lvl = ~tx_busy; // R09
          FN_TXEN_HIGH: lvl = tx_busy; // R09
          default: drive = 1'b0;
        endcase
      end
      // registered so pads never glitch on a decode change
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          line_o[g] <= 1'b0;
          line_oen_o[g] <= 1'b1;
          adc_en_o[g] <= 1'b0;
          din_o[g] <= 1'b0;
        end else begin
          line_o[g] <= lvl;
          line_oen_o[g] <= ~drive; // low while driving
          adc_en_o[g] <= (fn[g] == FN_ADC);
          din_o[g] <= (fn[g] == FN_DIN) & line_i[g];
        end
      end
    end
  endgenerate

  // line eight: input only
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) din_o[8] <= 1'b0;
    else din_o[8] <= (l8_reg == FN_DIN) & line8_i; // R08
  end

  assign pullup_o = {pullup_reg[PU_DIN_BIT], pullup_reg[PU_SLEEP_BIT],
                     pullup_reg[PU_RTS_BIT], pullup_reg[0], pullup_reg[1],
                     pullup_reg[2], pullup_reg[3], pullup_reg[4]}; // R07
  assign framed_mode_o = framed_reg; // R05
  assign parity_o = parity_reg[2:0]; // R06

  ////////////////////////////////////////////////////////////////////////////
  // receiver: sample mid-bit, eight data bits plus optional parity
  logic [31:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh;
  logic rx_act, rx_done;
  logic [3:0] nbits;
  assign nbits = (parity_reg[2:0] == PAR_NONE) ? BITS_NOPAR : BITS_PAR; // R06
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_act <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_act) begin
        if (!rxd_i) begin
          rx_act <= 1'b1;
          rx_cnt <= div_reg >> 1;
          rx_bit <= '0;
        end
      end else if (rx_cnt == '0) begin
        rx_cnt <= div_reg - 32'h00000001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == nbits - 4'h1) begin
          rx_act <= 1'b0;
          rx_done <= 1'b1;
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rxd_i, rx_sh[8:1]};
        end
      end else begin
        rx_cnt <= rx_cnt - 32'h00000001;
      end
    end
  end
  logic [7:0] rx_byte;
  assign rx_byte = (nbits == BITS_PAR) ? rx_sh[7:0] : rx_sh[8:1];

  // idle gap: character times of quiet line end the packet
  logic [31:0] idle_cnt;
  logic [7:0] gap_cnt;
  logic gap_hit, pending;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      idle_cnt <= '0;
      gap_cnt <= '0;
      pending <= 1'b0;
    end else if (rx_act || rx_done) begin
      idle_cnt <= '0;
      gap_cnt <= '0;
      pending <= (gap_reg != 8'h00); // R04
    end else if (pending) begin
      if (idle_cnt >= div_reg * 32'(nbits) - 32'h00000001) begin
        idle_cnt <= '0;
        gap_cnt <= gap_cnt + 8'h01;
      end else begin
        idle_cnt <= idle_cnt + 32'h00000001;
      end
      if (gap_hit) pending <= 1'b0;
    end
  end
  assign gap_hit = pending && (gap_cnt == gap_reg); // R03

  // two-entry buffer toward the radio; the last flag closes the packet
  hsio_byte_t buf_q [2];
  logic wr_ptr, rd_ptr, push, pop, held;
  assign push = rx_done & (buf_cnt != 2'h2);
  assign pop = pkt_valid_o & pkt_ready_i;
  // held word waits one edge after the gap so its last flag is set before it is offered
  assign pkt_valid_o = (buf_cnt != 2'h0) & (~held | (gap_reg == 8'h00));
  assign held = (buf_cnt == 2'h1) & pending;
  assign pkt_o = buf_q[rd_ptr];
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      buf_cnt <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) begin
        buf_q[wr_ptr] <= '{last: (gap_reg == 8'h00), data: rx_byte}; // R04
        wr_ptr <= ~wr_ptr;
      end
      if (gap_hit && buf_cnt != 2'h0) buf_q[~wr_ptr].last <= 1'b1; // R03
      if (pop) rd_ptr <= ~rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: forwards remote I/O bytes when enabled
  logic [31:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [10:0] tx_sh;
  logic par;
  always_comb begin
    par = 1'b0;
    unique case (parity_reg[2:0])
      PAR_EVEN: par = ^rio_data_i;
      PAR_ODD: par = ~^rio_data_i;
      PAR_MARK: par = 1'b1;
      default: par = 1'b0;
    endcase
  end
  assign rio_ready_o = ~tx_busy & ~rts_stop & fwd_reg[0]; // R13 R15
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tx_busy <= 1'b0;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '1;
      txd_o <= 1'b1;
    end else if (!tx_busy) begin
      txd_o <= 1'b1;
      if (rio_valid_i && rio_ready_o) begin
        tx_busy <= 1'b1;
        tx_cnt <= div_reg - 32'h00000001;
        tx_bit <= '0;
        tx_sh <= (nbits == BITS_PAR) ? {1'b1, par, rio_data_i, 1'b0}
                                     : {2'b11, rio_data_i, 1'b0}; // R06
        txd_o <= 1'b0;
      end
    end else if (tx_cnt == '0) begin
      tx_cnt <= div_reg - 32'h00000001;
      tx_bit <= tx_bit + 4'h1;
      tx_sh <= {1'b1, tx_sh[10:1]};
      txd_o <= tx_sh[1];
      if (tx_bit == nbits - 4'h1) tx_busy <= 1'b0;
    end else begin
      tx_cnt <= tx_cnt - 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_bad_write_kept;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (cmd_i.wr && !ok && cmd_i.sel == HSIO_SEL_FRAMED) |=> $stable(framed_reg) && rsp_o.err;
  endproperty
  a_bad_write_kept: assert property (p_bad_write_kept) else $error("bad write changed reg"); // R14
  property p_line8_legal;
    @(posedge ref_clk_i) disable iff (!rstn_i) (l8_reg == FN_DISABLED) || (l8_reg == FN_DIN);
  endproperty
  a_line8_legal: assert property (p_line8_legal) else $error("line eight code illegal"); // R08
  property p_framed_range;
    @(posedge ref_clk_i) disable iff (!rstn_i) framed_reg <= FRAMED_MAX;
  endproperty
  a_framed_range: assert property (p_framed_range) else $error("framed mode out of range"); // R05
  property p_rio_gate;
    @(posedge ref_clk_i) disable iff (!rstn_i) (fwd_reg == 8'h00) |-> !rio_ready_o;
  endproperty
  a_rio_gate: assert property (p_rio_gate) else $error("forwarding while disabled"); // R13
  property p_zero_gap_last;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (pkt_valid_o && gap_reg == 8'h00 && $stable(gap_reg)) |-> pkt_o.last;
  endproperty
  a_zero_gap_last: assert property (p_zero_gap_last) else $error("zero gap packet not single"); // R04
  property p_rts_pause;
    @(posedge ref_clk_i) disable iff (!rstn_i) rts_stop |-> !rio_ready_o;
  endproperty
  a_rts_pause: assert property (p_rts_pause) else $error("sent while host not ready"); // R15
  property p_aline_code1;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (cmd_i.wr && cmd_i.sel == HSIO_SEL_ALINE && cmd_i.data == 32'(FN_SPECIAL)) |=> rsp_o.err;
  endproperty
  a_aline_code1: assert property (p_aline_code1) else $error("code one accepted on analog line"); // R12
  property p_rate_ns;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (cmd_i.wr && cmd_i.sel == HSIO_SEL_RATE && cmd_i.data == BAUD_NS_MIN) |=> !rsp_o.err ##1
      (rate_reg == 32'(CLK_HZ) / (32'(CLK_HZ) / BAUD_NS_MIN));
  endproperty
  a_rate_ns: assert property (p_rate_ns) else $error("achieved rate wrong"); // R02
  c_gap_end: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) gap_hit);
  c_buf_full: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) buf_cnt == 2'h2);
  c_tx_frame: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $fell(tx_busy));
endmodule : hsio_core
`default_nettype wire

// File: test/hsio_host_model.sv
// host-side serial model that drives the block's receive pin
// assumes the caller passes the bit period in clock cycles
`timescale 1ns/1ns
`default_nettype none
module hsio_host_model (
  // clock
  input wire logic ref_clk_i,
  // serial line toward the block
  output var logic rxd_o
);
  import hsio_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // idle high, the pin carries a pull-up
  initial rxd_o = 1'b1;
  // one character: start, eight data bits lsb first, optional parity, stop
  task automatic send(input logic [7:0] b, input logic [2:0] par, input int div);
    logic [10:0] f;
    logic pb;
    int nb;
    nb = (par == PAR_NONE) ? 10 : 11;
    pb = (par == PAR_EVEN) ? ^b : (par == PAR_ODD) ? ~^b : (par == PAR_MARK);
    f = (par == PAR_NONE) ? {2'b11, b, 1'b0} : {1'b1, pb, b, 1'b0};
    // each bit lasts div cycles, so any rate code can be modelled
    for (int k = 0; k < nb; k++) begin
      @(posedge ref_clk_i);
      rxd_o <= f[k];
      repeat (div - 1) @(posedge ref_clk_i);
    end
  endtask : send
endmodule : hsio_host_model
`default_nettype wire

// File: test/tb.sv
// self-checking testbench for the host serial and I/O line block
// assumes hsio_pkg and the host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hsio_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // 250 kb/s keeps character times short
  localparam int DIV = 500;
  localparam int CHAR = 10 * DIV;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  hsio_cmd_t cmd_i = '0;
  hsio_rsp_t rsp_o;
  hsio_byte_t pkt_o;
  logic rxd_i, txd_o, pkt_valid_o, rio_ready_o;
  logic pkt_ready_i = 1'b0, rio_valid_i = 1'b0, line8_i = 1'b0, assoc_blink_i = 1'b0;
  logic [7:0] rio_data_i = 8'h00, line_i = 8'h00;
  logic [7:0] line_o, line_oen_o, pullup_o, adc_en_o, framed_mode_o;
  logic [8:0] din_o;
  logic [2:0] parity_o;
  int fail_count = 0;
  int checks = 0;
  logic rerr;
  logic [31:0] rdat;
  // clock
  always #4 ref_clk_i = ~ref_clk_i;
  hsio_core u_dut (.ref_clk_i, .rstn_i, .cmd_i, .rsp_o, .rxd_i, .txd_o, .pkt_o, .pkt_valid_o,
    .pkt_ready_i, .rio_data_i, .rio_valid_i, .rio_ready_o, .line_i, .line_o, .line_oen_o,
    .line8_i, .assoc_blink_i, .pullup_o, .adc_en_o, .din_o, .framed_mode_o, .parity_o);
  hsio_host_model u_host (.ref_clk_i, .rxd_o(rxd_i));
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // one command, answer looked at in its single valid cycle
  task automatic cfg(input logic w, input hsio_sel_t s, input logic [2:0] i,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    cmd_i <= '{wr: w, rd: !w, sel: s, idx: i, data: d};
    @(posedge ref_clk_i);
    cmd_i <= '0;
    #1;
    chk(rsp_o.valid, 1'b1);
    rerr = rsp_o.err;
    rdat = rsp_o.data;
  endtask : cfg
  task automatic wr(input hsio_sel_t s, input logic [2:0] i, input logic [31:0] d,
                    input logic e);
    cfg(1'b1, s, i, d);
    chk(rerr, e);
  endtask : wr
  task automatic rd(input hsio_sel_t s, input logic [2:0] i, input logic [31:0] e);
    cfg(1'b0, s, i, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wait_n
  // values read just after the edge are the ones the edge sampled
  // ready stays low between calls, so no word is popped unseen
  task automatic get_pkt(input logic [7:0] d, input logic l, input int lim);
    int n = 0;
    @(posedge ref_clk_i);
    pkt_ready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pkt_valid_o !== 1'b1 && n < lim);
    pkt_ready_i <= 1'b0;
    chk(n < lim, 1'b1);
    chk(pkt_o, {l, d});
  endtask : get_pkt
  task automatic rio_wait(output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rio_ready_o !== 1'b1 && n < 100);
  endtask : rio_wait
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [31:0] exp [11] = '{BAUD_RESET, GAP_RESET, FRAMED_RESET, PARITY_RESET,
      PULLUP_RESET, L8_RESET, L7_RESET, L6_RESET, L5_RESET, ALINE_RESET, FWD_RESET};
    for (int k = 0; k < 11; k++) rd(hsio_sel_t'(k), 3'h0, exp[k]);
    chk(pullup_o, 8'hFF);
    chk({line_oen_o[7], line_oen_o[5], txd_o}, 3'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_range();
    wr(HSIO_SEL_FRAMED, 3'h0, 32'h3, 1'b1);
    rd(HSIO_SEL_FRAMED, 3'h0, 32'h0);
    wr(HSIO_SEL_FRAMED, 3'h0, 32'h2, 1'b0);
    chk(framed_mode_o, 8'h02);
    wr(HSIO_SEL_PARITY, 3'h0, 32'h5, 1'b1);
    wr(HSIO_SEL_PARITY, 3'h0, 32'h4, 1'b0);
    chk(parity_o, PAR_SPACE);
    wr(HSIO_SEL_FWD, 3'h0, 32'h2, 1'b1);
    wr(HSIO_SEL_RATE, 3'h0, 32'h8, 1'b1);
    wr(HSIO_SEL_RATE, 3'h0, 32'h3D091, 1'b1);
    wr(HSIO_SEL_RATE, 3'h0, 32'h7, 1'b0);
    rd(HSIO_SEL_RATE, 3'h0, 32'h7);
    wr(HSIO_SEL_RATE, 3'h0, 32'h80, 1'b0);
    rd(HSIO_SEL_RATE, 3'h0, CLK_HZ / (CLK_HZ / 128));
    wr(HSIO_SEL_RATE, 3'h0, 32'h1C200, 1'b0);
    rd(HSIO_SEL_RATE, 3'h0, CLK_HZ / (CLK_HZ / 115200));
    wr(HSIO_SEL_RATE, 3'h0, 32'h3D090, 1'b0);
    rd(HSIO_SEL_RATE, 3'h0, 32'h3D090);
    wr(HSIO_SEL_PARITY, 3'h0, 32'h0, 1'b0);
    wr(HSIO_SEL_PULLUP, 3'h0, 32'h01, 1'b0);
    chk(pullup_o, 8'h10);
    wr(HSIO_SEL_PULLUP, 3'h0, 32'hE2, 1'b0);
    chk(pullup_o, 8'hE8);
    $display("range test done");
  endtask : t_range
  task automatic t_lines();
    wr(HSIO_SEL_L8, 3'h0, 32'h1, 1'b1);
    wr(HSIO_SEL_L8, 3'h0, 32'h3, 1'b0);
    wr(HSIO_SEL_L6, 3'h0, 32'h2, 1'b1);
    wr(HSIO_SEL_ALINE, 3'h2, 32'h1, 1'b1);
    wr(HSIO_SEL_ALINE, 3'h2, 32'h2, 1'b0);
    wr(HSIO_SEL_ALINE, 3'h3, 32'h3, 1'b0);
    wr(HSIO_SEL_L5, 3'h0, 32'h2, 1'b0);
    wr(HSIO_SEL_L6, 3'h0, 32'h4, 1'b0);
    wr(HSIO_SEL_L7, 3'h0, 32'h5, 1'b0);
    @(posedge ref_clk_i);
    line8_i <= 1'b1;
    line_i[3] <= 1'b1;
    wait_n(3);
    chk({din_o[8], din_o[3]}, 2'h3);
    chk(adc_en_o, 8'h24);
    chk({line_oen_o[7:6], line_o[7:6]}, 4'h2);
    // transceiver enable codes, both polarities while idle
    wr(HSIO_SEL_L7, 3'h0, 32'h6, 1'b0);
    wait_n(3);
    chk(line_o[7], 1'b1);
    wr(HSIO_SEL_L7, 3'h0, 32'h7, 1'b0);
    wait_n(3);
    chk(line_o[7], 1'b0);
    wr(HSIO_SEL_L7, 3'h0, 32'h1, 1'b0);
    wr(HSIO_SEL_L6, 3'h0, 32'h0, 1'b0);
    wr(HSIO_SEL_L5, 3'h0, 32'h1, 1'b0);
    @(posedge ref_clk_i);
    assoc_blink_i <= 1'b1;
    wait_n(3);
    chk({line_oen_o[5], line_o[5]}, 2'h1);
    $display("line test done");
  endtask : t_lines
  task automatic t_rx();
    time t;
    wr(HSIO_SEL_GAP, 3'h0, 32'h0, 1'b0);
    u_host.send(8'hA5, PAR_NONE, DIV);
    get_pkt(8'hA5, 1'b1, 1000);
    wr(HSIO_SEL_PARITY, 3'h0, 32'h1, 1'b0);
    u_host.send(8'h3C, PAR_EVEN, DIV);
    get_pkt(8'h3C, 1'b1, 1000);
    wr(HSIO_SEL_PARITY, 3'h0, 32'h0, 1'b0);
    // receiver stalls: two bytes fill the buffer, a third is dropped
    u_host.send(8'h11, PAR_NONE, DIV);
    u_host.send(8'h22, PAR_NONE, DIV);
    wait_n(4);
    chk(line_o[7], 1'b1);
    u_host.send(8'h33, PAR_NONE, DIV);
    get_pkt(8'h11, 1'b1, 50);
    get_pkt(8'h22, 1'b1, 50);
    wait_n(200);
    chk({pkt_valid_o, line_o[7]}, 2'h0);
    // gap of two character times holds the last byte
    wr(HSIO_SEL_GAP, 3'h0, 32'h2, 1'b0);
    u_host.send(8'h41, PAR_NONE, DIV);
    u_host.send(8'h42, PAR_NONE, DIV);
    t = $time;
    get_pkt(8'h41, 1'b0, CHAR);
    get_pkt(8'h42, 1'b1, 4 * CHAR);
    chk((($time - t) / 8) inside {[2 * CHAR - 2 * DIV : 3 * CHAR]}, 1'b1);
    $display("receive test done");
  endtask : t_rx
  task automatic t_rio();
    int n;
    logic [8:0] tx_word;
    wr(HSIO_SEL_FWD, 3'h0, 32'h0, 1'b0);
    @(posedge ref_clk_i);
    rio_data_i <= 8'h5A;
    rio_valid_i <= 1'b1;
    line_i[6] <= 1'b1;
    rio_wait(n);
    chk(n, 100);
    wr(HSIO_SEL_L6, 3'h0, 32'h1, 1'b0);
    wr(HSIO_SEL_FWD, 3'h0, 32'h1, 1'b0);
    rio_wait(n);
    chk(n, 100);
    @(posedge ref_clk_i);
    line_i[6] <= 1'b0;
    rio_wait(n);
    chk(n < 100, 1'b1);
    rio_valid_i <= 1'b0;
    n = 0;
    while (txd_o !== 1'b0 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(n < 2000, 1'b1);
    // sample each bit in its middle: eight data bits lsb first, then the stop bit
    repeat (DIV / 2 - 1) @(posedge ref_clk_i);
    for (int k = 0; k < 9; k++) begin
      repeat (DIV) @(posedge ref_clk_i);
      tx_word[k] = txd_o;
    end
    chk(tx_word, 9'h15A);
    $display("forward test done");
  endtask : t_rio
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, the single place where the run ends
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_range();
    t_lines();
    t_rx();
    t_rio();
    stop_test();
  end
  // watchdog, the tests need about fifty thousand cycles
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : tb
`default_nettype wire
